// ===== src/asr_host.sv
// Host end: AXI4-Lite registers and the external-clock read sequence
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "asr_regs.svh"
module asr_host (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic [31:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [31:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	asr_link_if.host         link
);
	localparam logic [2:0] PULSE_END = 3'(`ASR_PULSE_CYC - 1);
	localparam logic [2:0] HALF_END  = 3'(`ASR_HALF_CYC - 1);

	logic [1:0] syncIn;
	logic       busyHigh;
	logic       sdLvl;

	asr_sync #(
		.W       (2),
		.RST_VAL (2'h2)
	) uSync (
		.mclk  (mclk),
		.rst_b (rst_b),
		.din   ({link.busyB, link.serialOut}),
		.dout  (syncIn)
	);
	assign busyHigh = syncIn[1];
	assign sdLvl    = syncIn[0];

	//------------------------------------------------------------
	// AXI4-Lite slave
	//------------------------------------------------------------
	logic [31:0] awAddr_ff;
	logic [31:0] wData_ff;
	logic [3:0]  wStrb_ff;
	logic        doWrite;
	logic        wrCtrl;
	logic        wrStat;
	logic        chain_ff;
	logic        done_ff;
	logic [31:0] data_ff;
	logic        startPulse;
	asr_pkg::asr_host_state_t state_ff;

	assign doWrite = ~awready & ~wready & ~bvalid;
	assign wrCtrl  = doWrite && awAddr_ff == `ASR_CTRL_OFS && wStrb_ff[0];
	assign wrStat  = doWrite && awAddr_ff == `ASR_STATUS_OFS && wStrb_ff[0];
	assign startPulse = wrCtrl && wData_ff[`ASR_CTRL_START];

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			awready   <= 1'b1;
			awAddr_ff <= 32'h0000_0000;
		end else if (awvalid && awready) begin
			awready   <= 1'b0;
			awAddr_ff <= awaddr;
		end else if (bvalid && bready) begin
			awready <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			wready   <= 1'b1;
			wData_ff <= 32'h0000_0000;
			wStrb_ff <= 4'h0;
		end else if (wvalid && wready) begin
			wready   <= 1'b0;
			wData_ff <= wdata;
			wStrb_ff <= wstrb;
		end else if (bvalid && bready) begin
			wready <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			bvalid <= 1'b0;
			bresp  <= `ASR_RESP_OKAY;
		end else if (doWrite) begin
			bvalid <= 1'b1;
			bresp  <= (awAddr_ff == `ASR_CTRL_OFS || awAddr_ff == `ASR_STATUS_OFS) ?
				`ASR_RESP_OKAY : `ASR_RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `ASR_RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= `ASR_RESP_OKAY;
			case (araddr)
				`ASR_CTRL_OFS:   rdata <= {30'h0, chain_ff, 1'b0};
				`ASR_STATUS_OFS: rdata <= {30'h0, done_ff, state_ff != asr_pkg::H_IDLE};
				`ASR_DATA_OFS:   rdata <= data_ff;
				default: begin
					rdata <= 32'h0000_0000;
					rresp <= `ASR_RESP_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			chain_ff <= `ASR_CHAIN_RST;
		end else if (wrCtrl) begin
			chain_ff <= wData_ff[`ASR_CTRL_CHAIN];
		end
	end

	// Finishing sets done even when software clears it in the same cycle
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			done_ff <= 1'b0;
		end else if (state_ff == asr_pkg::H_FINISH) begin
			done_ff <= 1'b1;
		end else if (wrStat && wData_ff[`ASR_STAT_DONE]) begin
			done_ff <= 1'b0;
		end
	end

	//------------------------------------------------------------
	// Link sequencer
	//------------------------------------------------------------
	logic [2:0]  tmr_ff;
	logic [5:0]  pulse_ff;
	logic [5:0]  nBits;
	logic [31:0] rx_ff;

	assign nBits = chain_ff ? `ASR_BITS_TWO : `ASR_BITS_ONE;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state_ff         <= asr_pkg::H_IDLE;
			link.csB         <= 1'b1;
			link.rdConv      <= 1'b1;
			link.shiftClock  <= 1'b0;
			link.clockSelect <= 1'b1;
			tmr_ff           <= 3'h0;
			pulse_ff         <= 6'h00;
		end else begin
			case (state_ff)
				asr_pkg::H_IDLE: begin
					if (startPulse) begin
						link.csB <= 1'b0;
						state_ff <= asr_pkg::H_SELECT;
					end
				end
				asr_pkg::H_SELECT: begin
					link.rdConv <= 1'b0;
					tmr_ff      <= 3'h0;
					state_ff    <= asr_pkg::H_CONVERT;
				end
				asr_pkg::H_CONVERT: begin
					tmr_ff <= tmr_ff + 3'h1;
					if (tmr_ff == PULSE_END) begin
						link.rdConv <= 1'b1;
						state_ff    <= asr_pkg::H_WAITLOW;
					end
				end
				asr_pkg::H_WAITLOW: begin
					if (!busyHigh) begin
						state_ff <= asr_pkg::H_WAITHIGH;
					end
				end
				asr_pkg::H_WAITHIGH: begin
					// Clock held low for the whole conversion
					if (busyHigh) begin
						tmr_ff   <= 3'h0;
						pulse_ff <= 6'h00;
						state_ff <= asr_pkg::H_SHIFT;
					end
				end
				asr_pkg::H_SHIFT: begin
					tmr_ff <= tmr_ff + 3'h1;
					if (tmr_ff == HALF_END) begin
						tmr_ff          <= 3'h0;
						link.shiftClock <= ~link.shiftClock;
						if (link.shiftClock) begin
							pulse_ff <= pulse_ff + 6'h01;
							if (pulse_ff == nBits) begin
								state_ff <= asr_pkg::H_FINISH;
							end
						end
					end
				end
				asr_pkg::H_FINISH: begin
					link.csB <= 1'b1;
					state_ff <= asr_pkg::H_IDLE;
				end
				default: begin
					state_ff <= asr_pkg::H_IDLE;
				end
			endcase
		end
	end

	// Bit k is sampled at the end of the high half of pulse k+1
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rx_ff <= 32'h0000_0000;
		end else if (state_ff == asr_pkg::H_WAITHIGH) begin
			rx_ff <= 32'h0000_0000;
		end else if (state_ff == asr_pkg::H_SHIFT && tmr_ff == HALF_END &&
			link.shiftClock && pulse_ff != 6'h00) begin
			rx_ff <= {rx_ff[30:0], sdLvl};
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			data_ff <= `ASR_DATA_RST;
		end else if (state_ff == asr_pkg::H_FINISH) begin
			data_ff <= rx_ff;
		end
	end
endmodule

// ===== src/asr_regs.svh
// Timing counts, register map and field positions of the serial readout link
//------------------------------------------------------------
//------------------------------------------------------------
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH

//------------------------------------------------------------
// Timing
//------------------------------------------------------------
`define ASR_MCLK_NS       20
`define ASR_RESULT_W      16
`define ASR_LOAD_NS       2200
`define ASR_LOAD_CYC      (`ASR_LOAD_NS / `ASR_MCLK_NS)
`define ASR_BUSY_LOW_NS   2300
`define ASR_BUSY_CYC      (`ASR_BUSY_LOW_NS / `ASR_MCLK_NS)
`define ASR_CONV_PULSE_NS 40
`define ASR_PULSE_CYC     ((`ASR_CONV_PULSE_NS + `ASR_MCLK_NS - 1) / `ASR_MCLK_NS)
`define ASR_SCK_HALF_NS   80
`define ASR_HALF_CYC      ((`ASR_SCK_HALF_NS + `ASR_MCLK_NS - 1) / `ASR_MCLK_NS)
`define ASR_BITS_ONE      6'h10
`define ASR_BITS_TWO      6'h20

//------------------------------------------------------------
// Register map
//------------------------------------------------------------
`define ASR_CTRL_OFS      32'h0000_0000
`define ASR_STATUS_OFS    32'h0000_0004
`define ASR_DATA_OFS      32'h0000_0008
`define ASR_CTRL_START    0
`define ASR_CTRL_CHAIN    1
`define ASR_STAT_ACTIVE   0
`define ASR_STAT_DONE     1
`define ASR_CHAIN_RST     1'b0
`define ASR_DATA_RST      32'h0000_0000
`define ASR_RESP_OKAY     2'b00
`define ASR_RESP_SLVERR   2'b10

`endif

// ===== src/asr_pkg.sv
// Types shared by the two ends of the serial readout link
package asr_pkg;
	typedef enum logic [0:0] {DEV_IDLE, DEV_CONVERT} asr_dev_state_t;
	typedef enum logic [2:0] {
		H_IDLE, H_SELECT, H_CONVERT, H_WAITLOW, H_WAITHIGH, H_SHIFT, H_FINISH
	} asr_host_state_t;
endpackage

// ===== src/asr_link_if.sv
// Pin bundle between the converter end and the host end
`timescale 1ns/1ps
interface asr_link_if;
	logic csB;
	logic rdConv;
	logic shiftClock;
	logic clockSelect;
	logic busyB;
	logic serialOut;

	modport dev (
		input  csB,
		input  rdConv,
		input  shiftClock,
		input  clockSelect,
		output busyB,
		output serialOut
	);

	modport host (
		output csB,
		output rdConv,
		output shiftClock,
		output clockSelect,
		input  busyB,
		input  serialOut
	);
endinterface

// ===== src/asr_sync.sv
// Two-stage synchroniser for a group of unrelated level inputs
`timescale 1ns/1ps
module asr_sync #(
	parameter int            W       = 1,
	parameter logic [W-1:0]  RST_VAL = '0
) (
	input  wire logic         mclk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : gBit
			always_ff @(posedge mclk) begin
				if (!rst_b) begin
					meta_ff[i] <= RST_VAL[i];
					sync_ff[i] <= RST_VAL[i];
				end else begin
					meta_ff[i] <= din[i];
					sync_ff[i] <= meta_ff[i];
				end
			end
		end
	endgenerate

	assign dout = sync_ff;
endmodule

// ===== src/asr_device.sv
// Converter end: conversion timing, result load and serial shifting
`timescale 1ns/1ps
`include "asr_regs.svh"
module asr_device (
	asr_link_if.dev                    link,
	input  wire logic                  mclk,
	input  wire logic                  rst_b,
	input  wire logic [`ASR_RESULT_W-1:0] sampleIn,
	input  wire logic                  chainIn,
	output logic                       resultLoaded,
	output logic                       loadLost,
	output logic                       converting
);
	//------------------------------------------------------------
	// Input synchronisation
	//------------------------------------------------------------
	localparam int IN_W = 5;
	localparam logic [IN_W-1:0] IN_RST = 5'h18;
	localparam logic [7:0] LOAD_AT = 8'(`ASR_LOAD_CYC - 1);
	localparam logic [7:0] BUSY_END = 8'(`ASR_BUSY_CYC - 1);

	logic [IN_W-1:0] rawIn;
	logic [IN_W-1:0] syncIn;
	logic            selLow;
	logic            rdHigh;
	logic            sckLvl;
	logic            extClk;
	logic            chainLvl;

	assign rawIn = {link.csB, link.rdConv, link.shiftClock, link.clockSelect, chainIn};

	asr_sync #(
		.W       (IN_W),
		.RST_VAL (IN_RST)
	) uSync (
		.mclk  (mclk),
		.rst_b (rst_b),
		.din   (rawIn),
		.dout  (syncIn)
	);

	assign selLow   = ~syncIn[4];
	assign rdHigh   = syncIn[3];
	assign sckLvl   = syncIn[2];
	assign extClk   = syncIn[1];
	assign chainLvl = syncIn[0];

	//------------------------------------------------------------
	// Edge and command detection
	//------------------------------------------------------------
	logic sckPrev_ff;
	logic convPrev_ff;
	logic sckRise;
	logic sckFall;
	logic shiftEn;
	logic convReq;
	logic convStart;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			sckPrev_ff <= 1'b0;
		end else begin
			sckPrev_ff <= sckLvl;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			convPrev_ff <= 1'b0;
		end else begin
			convPrev_ff <= convReq;
		end
	end

	assign sckRise   = sckLvl & ~sckPrev_ff;
	assign sckFall   = ~sckLvl & sckPrev_ff;
	assign shiftEn   = selLow & rdHigh & extClk;
	assign convReq   = selLow & ~rdHigh;
	assign convStart = convReq & ~convPrev_ff;

	//------------------------------------------------------------
	// Conversion sequencer
	//------------------------------------------------------------
	asr_pkg::asr_dev_state_t state_ff;
	logic [7:0]              cnt_ff;
	logic                    loadEvt;
	logic                    lossNow;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state_ff <= asr_pkg::DEV_IDLE;
		end else begin
			case (state_ff)
				asr_pkg::DEV_IDLE: begin
					if (convStart) begin
						state_ff <= asr_pkg::DEV_CONVERT;
					end
				end
				asr_pkg::DEV_CONVERT: begin
					// Further convert commands are not looked at here
					if (cnt_ff == BUSY_END) begin
						state_ff <= asr_pkg::DEV_IDLE;
					end
				end
				default: begin
					state_ff <= asr_pkg::DEV_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cnt_ff <= 8'h00;
		end else if (state_ff == asr_pkg::DEV_IDLE) begin
			cnt_ff <= 8'h00;
		end else begin
			cnt_ff <= cnt_ff + 8'h01;
		end
	end

	// Busy low for the whole conversion, raised only after the load
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			link.busyB <= 1'b1;
		end else if (state_ff == asr_pkg::DEV_IDLE && convStart) begin
			link.busyB <= 1'b0;
		end else if (state_ff == asr_pkg::DEV_CONVERT && cnt_ff == BUSY_END) begin
			link.busyB <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			converting <= 1'b0;
		end else if (state_ff == asr_pkg::DEV_IDLE && convStart) begin
			converting <= 1'b1;
		end else if (state_ff == asr_pkg::DEV_CONVERT && cnt_ff == BUSY_END) begin
			converting <= 1'b0;
		end
	end

	// Load point sits at cycle LOAD_AT of the conversion, 5 cycles before busy rises
	assign loadEvt = (state_ff == asr_pkg::DEV_CONVERT) && (cnt_ff == LOAD_AT);
	// A shift clock held high in the read window at the load point spoils the transfer
	assign lossNow = loadEvt & shiftEn & sckLvl;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			resultLoaded <= 1'b0;
		end else begin
			resultLoaded <= loadEvt & ~lossNow;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			loadLost <= 1'b0;
		end else begin
			loadLost <= lossNow;
		end
	end

	//------------------------------------------------------------
	// Output shift path
	//------------------------------------------------------------
	logic [`ASR_RESULT_W-1:0] word_ff;
	logic                     chainBit_ff;

	// One chain bit caught on every rising shift-clock edge inside the read window (shiftEn)
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			chainBit_ff <= 1'b0;
		end else if (shiftEn && sckRise) begin
			chainBit_ff <= chainLvl;
		end
	end

	// Old word stays until the load; chain bits fill in behind the result
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			word_ff <= '0;
		end else if (loadEvt && !lossNow) begin
			word_ff <= sampleIn;
		end else if (shiftEn && sckFall) begin
			word_ff <= {word_ff[`ASR_RESULT_W-2:0], chainBit_ff};
		end
	end

	// Serial pin always driven from a flop, MSB out at the first fall
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			link.serialOut <= 1'b0;
		end else if (shiftEn && sckFall) begin
			link.serialOut <= word_ff[`ASR_RESULT_W-1];
		end
	end
endmodule

// ===== sim/asr_assertions.sv
// Concurrent checks on the pins between the converter end and the host end
`timescale 1ns/1ps
module asr_assertions (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic csB,
	input wire logic rdConv,
	input wire logic shiftClock,
	input wire logic clockSelect,
	input wire logic busyB,
	input wire logic serialOut
);
	//------------------------------------------------------------
	// Busy low length counter
	//------------------------------------------------------------
	logic [7:0] lowCnt_ff;

	always_ff @(posedge mclk) begin
		if (!rst_b || busyB) begin
			lowCnt_ff <= 8'h00;
		end else if (lowCnt_ff != 8'hff) begin
			lowCnt_ff <= lowCnt_ff + 8'h01;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	//------------------------------------------------------------
	// Properties
	//------------------------------------------------------------
	property p_ext_clk;
		clockSelect;
	endproperty
	a_ext_clk: assert property (p_ext_clk)
		else $error("clock select is not high");

	property p_clk_window;
		$rose(shiftClock) |-> !csB && rdConv;
	endproperty
	a_clk_window: assert property (p_clk_window)
		else $error("shift clock pulse outside the read window");

	property p_quiet;
		!busyB |-> !shiftClock;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("shift clock high during conversion");

	property p_busy_fall;
		$fell(rdConv) && !csB && busyB |-> ##[1:4] !busyB;
	endproperty
	a_busy_fall: assert property (p_busy_fall)
		else $error("busy did not fall after convert");

	property p_start;
		$fell(busyB) |-> !csB && ($past(rdConv, 2) == 1'b0 || $past(rdConv, 3) == 1'b0
			|| $past(rdConv, 4) == 1'b0 || $past(rdConv, 5) == 1'b0);
	endproperty
	a_start: assert property (p_start)
		else $error("conversion started without convert command");

	property p_busy_max;
		!busyB |-> lowCnt_ff < 8'h7d;
	endproperty
	a_busy_max: assert property (p_busy_max)
		else $error("busy low too long");

	property p_busy_min;
		$rose(busyB) |-> lowCnt_ff >= 8'h71 && lowCnt_ff <= 8'h75;
	endproperty
	a_busy_min: assert property (p_busy_min)
		else $error("busy low length wrong");

	property p_serial_idle;
		csB [*8] |=> $stable(serialOut);
	endproperty
	a_serial_idle: assert property (p_serial_idle)
		else $error("serial output moved while deselected");

	property p_serial_fall;
		$changed(serialOut) |-> !shiftClock;
	endproperty
	a_serial_fall: assert property (p_serial_fall)
		else $error("serial output changed while shift clock high");
endmodule

// ===== sim/testbench.sv
// Self-checking bench: register sequences driving both link ends
`timescale 1ns/1ps
`include "asr_regs.svh"
module testbench;
	//------------------------------------------------------------
	// Signals
	//------------------------------------------------------------
	logic        mclk    = 1'b0;
	logic        rst_b   = 1'b0;
	logic [31:0] awaddr  = 32'h0;
	logic [31:0] wdata   = 32'h0;
	logic [31:0] araddr  = 32'h0;
	logic [3:0]  wstrb   = 4'h0;
	logic        awvalid = 1'b0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic [15:0] sampleIn = 16'h0000;
	logic        chainIn  = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, resultLoaded, loadLost, converting;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	int          err_count = 0;
	int          total_checks = 0;
	int          loadCnt = 0;
	int          lostCnt = 0;
	logic [31:0] ctrlTab [2] = '{32'h1, 32'h3};
	logic [15:0] smpTab  [2] = '{16'ha5c3, 16'h3c5a};
	logic        chnTab  [2] = '{1'b0, 1'b1};
	logic [31:0] expTab  [2] = '{32'h0000a5c3, 32'h3c5affff};

	//------------------------------------------------------------
	// Instances
	//------------------------------------------------------------
	asr_link_if link_inst ();
	asr_device asr_device_inst (.link(link_inst), .mclk(mclk), .rst_b(rst_b),
		.sampleIn(sampleIn), .chainIn(chainIn), .resultLoaded(resultLoaded),
		.loadLost(loadLost), .converting(converting));
	asr_host asr_host_inst (.mclk(mclk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.link(link_inst));
	asr_assertions asr_assertions_inst (.mclk(mclk), .rst_b(rst_b), .csB(link_inst.csB),
		.rdConv(link_inst.rdConv), .shiftClock(link_inst.shiftClock),
		.clockSelect(link_inst.clockSelect), .busyB(link_inst.busyB),
		.serialOut(link_inst.serialOut));

	initial forever #10 mclk = ~mclk;

	// Counts load and lost pulses seen from the converter end
	always @(posedge mclk) begin
		if (resultLoaded === 1'b1) loadCnt <= loadCnt + 1;
		if (loadLost === 1'b1) lostCnt <= lostCnt + 1;
	end

	//------------------------------------------------------------
	// Tasks
	//------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		$display("Checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic timeout;
		err_count++;
		$display("[ERR] %0t wait limit reached", $time);
		final_report();
	endtask

	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge mclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		if (n == 64) timeout();
		bready <= 1'b0;
		check({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic axi_rd(input logic [31:0] a, input logic [1:0] er, output logic [31:0] d);
		int n;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge mclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		if (n == 64) timeout();
		rready <= 1'b0;
		d = rdata;
		check({30'h0, rresp}, {30'h0, er});
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic [31:0] d;
		axi_rd(a, er, d);
		check(d, exp);
	endtask

	task automatic wait_done;
		logic [31:0] st;
		int n;
		for (n = 0; n < 600; n++) begin
			axi_rd(`ASR_STATUS_OFS, `ASR_RESP_OKAY, st);
			if (st[1] === 1'b1) break;
		end
		if (n == 600) timeout();
	endtask

	//------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------
	initial begin
		int i;
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		rd_chk(`ASR_CTRL_OFS, 32'h0, `ASR_RESP_OKAY);
		rd_chk(`ASR_STATUS_OFS, 32'h0, `ASR_RESP_OKAY);
		rd_chk(`ASR_DATA_OFS, `ASR_DATA_RST, `ASR_RESP_OKAY);
		rd_chk(32'h0000_0010, 32'h0, `ASR_RESP_SLVERR);
		axi_wr(32'h0000_0010, 32'h1, 4'hf, `ASR_RESP_SLVERR);
		axi_wr(`ASR_DATA_OFS, 32'hffff_ffff, 4'hf, `ASR_RESP_SLVERR);
		rd_chk(`ASR_DATA_OFS, `ASR_DATA_RST, `ASR_RESP_OKAY);
		// Start with the low byte lane off must not convert
		axi_wr(`ASR_CTRL_OFS, 32'h1, 4'he, `ASR_RESP_OKAY);
		rd_chk(`ASR_STATUS_OFS, 32'h0, `ASR_RESP_OKAY);
		for (i = 0; i < 2; i++) begin
			sampleIn <= smpTab[i];
			chainIn <= chnTab[i];
			axi_wr(`ASR_CTRL_OFS, ctrlTab[i], 4'hf, `ASR_RESP_OKAY);
			// Second start lands while converting and is dropped
			axi_wr(`ASR_CTRL_OFS, ctrlTab[i], 4'hf, `ASR_RESP_OKAY);
			rd_chk(`ASR_STATUS_OFS, 32'h1, `ASR_RESP_OKAY);
			check({31'h0, converting}, 32'h1);
			check({31'h0, link_inst.busyB}, 32'h0);
			rd_chk(`ASR_CTRL_OFS, ctrlTab[i] & 32'h2, `ASR_RESP_OKAY);
			wait_done();
			rd_chk(`ASR_DATA_OFS, expTab[i], `ASR_RESP_OKAY);
			rd_chk(`ASR_STATUS_OFS, 32'h2, `ASR_RESP_OKAY);
			check({31'h0, converting}, 32'h0);
			check({31'h0, link_inst.busyB}, 32'h1);
			axi_wr(`ASR_STATUS_OFS, 32'h2, 4'hf, `ASR_RESP_OKAY);
			rd_chk(`ASR_STATUS_OFS, 32'h0, `ASR_RESP_OKAY);
			check(32'(loadCnt), 32'(i + 1));
			check(32'(lostCnt), 32'h0);
		end
		final_report();
	end
endmodule
